/* File: design/pot_i2c_slave.sv */
// serial slave front end of a quad programmable potentiometer
// assumes open-drain bus lines resolved outside, a datapath on the user side that
// drains received bytes, supplies read bytes and says when a write targets storage
//
// Summary of operation
// - after a storage write STOP, release data line and ignore address up to 5 ms
// - data steady while clock high; a change then is START or STOP
// - START is data falling with clock high; ignore the bus before it
// - upper four address bits carry the type identifier and must match
// - lower four address bits compare with the four strap inputs
// - acknowledge the address byte only on full match, else stay silent
// - receiver pulls data low in the ninth clock to acknowledge
// - once addressed for writing, acknowledge every received byte; the code stays silent instead while the two-entry receive buffer is full
// - on read, send 8 bits, release, sample master acknowledge, continue on it
// - without master acknowledge, stop sending and wait for STOP
// - instruction byte holds opcode, two register and two pot select bits
// - STOP ending a storage write starts programming; ignore all requests meanwhile
// - polling gets no acknowledge while busy and an acknowledge once done
// - at power-up each wiper loads from its stored setting zero
`timescale 1ns/1ns
`include "pot_i2c_params.svh"
module pot_i2c_slave
	import pot_i2c_pkg::*;
#(
	parameter int POWERUP_CYCLES = `POT_POWERUP_CYCLES,
	parameter int PROGRAM_CYCLES = `POT_PROGRAM_CYCLES
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// serial bus lines, data line open drain
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// strapped address pins
	input  wire logic       strap_addr_bit0,
	input  wire logic       strap_addr_bit1,
	input  wire logic       strap_addr_bit2,
	input  wire logic       strap_addr_bit3,
	// received bytes to the datapath
	output logic      [7:0] rx_data,
	output logic            rx_first,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	// read bytes from the datapath
	input  wire logic       read_next,
	input  wire logic [7:0] tx_data,
	output logic            tx_taken,
	// storage control
	input  wire logic       nv_commit,
	output logic            nv_busy,
	output logic            powered_up,
	output logic            recall_zero
);

	localparam int CW = 24;

	if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << CW)) begin : g_bad_pu
		$error("power-up cycle count out of range");
	end
	if (PROGRAM_CYCLES < 1 || PROGRAM_CYCLES >= (1 << CW)) begin : g_bad_prog
		$error("programming cycle count out of range");
	end

	// synchroniser and filter stages
	logic [1:0]  scl_sync;
	logic [1:0]  sda_sync;
	logic [3:0]  strap_s1;
	logic [3:0]  strap_s2;
	logic        scl_hold;
	logic        sda_hold;
	logic        scl_f;
	logic        sda_f;
	logic        scl_prev;
	logic        sda_prev;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;

	// transfer state
	link_state_t state;
	logic [3:0]  bit_count;
	logic [7:0]  shift;
	logic        first_byte;
	logic        wrote;
	logic        master_ack;
	logic        addr_match;

	// timers
	logic [CW-1:0] pu_count;
	logic [CW-1:0] prog_count;

	// buffer side
	logic        buf_push;
	logic        buf_in_ready;
	logic [8:0]  buf_out;

	// two flip-flops on every pin before any logic reads it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync <= {2{`POT_LINE_IDLE}};
			sda_sync <= {2{`POT_LINE_IDLE}};
			strap_s1 <= 4'h0;
			strap_s2 <= 4'h0;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			strap_s1 <= {strap_addr_bit3, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
			strap_s2 <= strap_s1;
		end
	end

	// a level must be seen on two samples in a row before the filtered line follows;
	// this rejects one-cycle spikes at the price of two cycles of lag behind the synchroniser
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_hold <= `POT_LINE_IDLE;
			sda_hold <= `POT_LINE_IDLE;
			scl_f    <= `POT_LINE_IDLE;
			sda_f    <= `POT_LINE_IDLE;
			scl_prev <= `POT_LINE_IDLE;
			sda_prev <= `POT_LINE_IDLE;
		end else begin
			scl_hold <= scl_sync[1];
			sda_hold <= sda_sync[1];
			if (scl_hold == scl_sync[1]) begin
				scl_f <= scl_hold;
			end
			if (sda_hold == sda_sync[1]) begin
				sda_f <= sda_hold;
			end
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	// edge and condition detection on the filtered lines
	assign scl_rise   = scl_f & ~scl_prev;
	assign scl_fall   = ~scl_f & scl_prev;
	assign start_seen = scl_f & scl_prev & sda_prev & ~sda_f;
	assign stop_seen  = scl_f & scl_prev & ~sda_prev & sda_f;
	assign addr_match = (shift[`POT_TYPE_MSB:`POT_TYPE_LSB] == `POT_TYPE_ID)
		&& (shift[3:0] == strap_s2);
	assign buf_push   = (state == ST_WR_BYTE) && scl_fall
		&& (bit_count == `POT_BYTE_BITS) && buf_in_ready;

	// power-up delay: the bus is ignored until it ends, then wipers recall setting zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pu_count    <= '0;
			powered_up  <= 1'b0;
			recall_zero <= 1'b0;
		end else begin
			recall_zero <= 1'b0;
			if (!powered_up) begin
				if (pu_count == CW'(POWERUP_CYCLES - 1)) begin
					powered_up  <= 1'b1;
					recall_zero <= 1'b1;
				end else begin
					pu_count <= pu_count + 1'b1;
				end
			end
		end
	end

	// programming cycle starts on the STOP that closes a storage write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prog_count <= '0;
			nv_busy    <= 1'b0;
		end else if (nv_busy) begin
			if (prog_count == CW'(PROGRAM_CYCLES - 1)) begin
				nv_busy <= 1'b0;
			end else begin
				prog_count <= prog_count + 1'b1;
			end
		end else if (stop_seen && wrote && nv_commit && state != ST_IDLE) begin
			nv_busy    <= 1'b1;
			prog_count <= '0;
		end
	end

	// transfer sequencer; the device only follows the master's clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			bit_count  <= 4'h0;
			shift      <= 8'h00;
			first_byte <= 1'b0;
			wrote      <= 1'b0;
			master_ack <= 1'b0;
			sda_oe     <= 1'b0;
			sda_out    <= 1'b0;
			tx_taken   <= 1'b0;
		end else begin
			sda_out  <= 1'b0;
			tx_taken <= 1'b0;
			if (!powered_up || nv_busy) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
				wrote  <= 1'b0;
			end else if (start_seen) begin
				state     <= ST_ADDR;
				bit_count <= 4'h0;
				sda_oe    <= 1'b0;
				wrote     <= 1'b0;
			end else if (stop_seen) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
				wrote  <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_WR_BYTE: begin
						if (scl_rise) begin
							shift     <= {shift[6:0], sda_f};
							bit_count <= bit_count + 1'b1;
						end else if (scl_fall && bit_count == `POT_BYTE_BITS) begin
							if (state == ST_ADDR) begin
								if (addr_match) begin
									sda_oe     <= 1'b1;
									state      <= ST_ADDR_ACK;
									first_byte <= 1'b1;
								end else begin
									state <= ST_IDLE;
								end
							end else if (buf_in_ready) begin
								sda_oe <= 1'b1;
								wrote  <= 1'b1;
								state  <= ST_WR_ACK;
							end else begin
								state <= ST_WAIT; // no room: byte refused by silence
							end
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							sda_oe    <= 1'b0;
							bit_count <= 4'h0;
							state     <= ST_WR_BYTE;
						end
					end
					ST_WR_ACK: begin
						if (scl_fall) begin
							first_byte <= 1'b0;
							bit_count  <= 4'h0;
							if (read_next) begin
								shift    <= tx_data;
								sda_oe   <= ~tx_data[7];
								tx_taken <= 1'b1;
								state    <= ST_RD_BYTE;
							end else begin
								sda_oe <= 1'b0;
								state  <= ST_WR_BYTE;
							end
						end
					end
					ST_RD_BYTE: begin
						if (scl_rise) begin
							bit_count <= bit_count + 1'b1;
						end else if (scl_fall) begin
							if (bit_count == `POT_BYTE_BITS) begin
								sda_oe <= 1'b0;
								state  <= ST_RD_ACK;
							end else begin
								shift  <= {shift[6:0], 1'b0};
								sda_oe <= ~shift[6];
							end
						end
					end
					ST_RD_ACK: begin
						if (scl_rise) begin
							master_ack <= ~sda_f;
						end else if (scl_fall) begin
							bit_count <= 4'h0;
							if (master_ack) begin
								shift    <= tx_data;
								sda_oe   <= ~tx_data[7];
								tx_taken <= 1'b1;
								state    <= ST_RD_BYTE;
							end else begin
								sda_oe <= 1'b0;
								state  <= ST_WAIT;
							end
						end
					end
					ST_WAIT: begin
						sda_oe <= 1'b0;
					end
					default: begin
						state  <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// received bytes travel through a two-entry buffer; a full buffer withholds the ack
	pot_byte_buffer #(
		.WIDTH (9)
	) u_rx_buffer (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_data   ({first_byte, shift}),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.out_data  (buf_out),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	assign rx_first = buf_out[8];
	assign rx_data  = buf_out[7:0];

endmodule

/* File: design/pot_i2c_params.svh */
// timing counts, identifier value and reset values for the potentiometer serial front end
// assumes the including file works with a 25 MHz system clock
`ifndef POT_I2C_PARAMS_SVH
`define POT_I2C_PARAMS_SVH

// system clock rate
`define POT_CLOCK_HZ            25000000
// power-up access delay in ms, read and write
`define POT_POWERUP_READ_MS     1
`define POT_POWERUP_WRITE_MS    1
// nonvolatile programming time in ms
`define POT_NV_PROGRAM_MS       5
// longest times round down to whole cycles
`define POT_POWERUP_CYCLES      ((`POT_POWERUP_READ_MS * (`POT_CLOCK_HZ / 1000)))
`define POT_PROGRAM_CYCLES      ((`POT_NV_PROGRAM_MS * (`POT_CLOCK_HZ / 1000)))
// device type identifier, arbitrary neutral value
`define POT_TYPE_ID             4'hA
// field positions in the address byte
`define POT_TYPE_MSB            7
`define POT_TYPE_LSB            4
// bits in one byte
`define POT_BYTE_BITS           4'h8
// reset level of the line filters (released bus reads high)
`define POT_LINE_IDLE           1'b1

`endif

/* File: design/pot_i2c_pkg.sv */
// types shared by the potentiometer serial front end
// assumes nothing of its surroundings
package pot_i2c_pkg;

	// transfer state of the serial slave
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR_BYTE  = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_RD_BYTE  = 3'b101,
		ST_RD_ACK   = 3'b110,
		ST_WAIT     = 3'b111
	} link_state_t;

endpackage

/* File: design/pot_byte_buffer.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock domain; output data come straight from registers
`timescale 1ns/1ns
module pot_byte_buffer #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	logic [WIDTH-1:0] skid_data;
	logic             push;
	logic             pop;

	if (WIDTH < 1) begin : g_bad_width
		$error("buffer width must be at least one");
	end

	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;

	// the skid slot catches a word while the output is held, so ready is a register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_data  <= '0;
			out_valid <= 1'b0;
			skid_data <= '0;
			in_ready  <= 1'b1;
		end else if (!out_valid || pop) begin
			if (!in_ready) begin
				out_data  <= skid_data;
				out_valid <= 1'b1;
				in_ready  <= 1'b1;
			end else if (push) begin
				out_data  <= in_data;
				out_valid <= 1'b1;
			end else begin
				out_valid <= 1'b0;
			end
		end else if (push) begin
			skid_data <= in_data;
			in_ready  <= 1'b0; // both slots full
		end
	end

endmodule

/* File: test/pot_i2c_chk.sv */
// concurrent checks on the ports of the serial slave front end
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ns
module pot_i2c_chk #(
	parameter int PROGRAM_CYCLES = 200
) (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] rx_data,
	input wire logic       rx_first,
	input wire logic       rx_valid,
	input wire logic       rx_ready,
	input wire logic       tx_taken,
	input wire logic       nv_commit,
	input wire logic       nv_busy,
	input wire logic       powered_up,
	input wire logic       recall_zero
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	int busy_cnt;
	// length of the current programming cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
		end
	end
	// a stalled byte must not move while the datapath is not ready
	sequence s_stall; rx_valid && !rx_ready; endsequence
	sequence s_held; rx_valid && $stable(rx_data) && $stable(rx_first); endsequence
	property p_od; sda_out == 1'b0; endproperty
	property p_busy_quiet; nv_busy |-> !sda_oe; endproperty
	property p_pwr_quiet; !powered_up |-> !sda_oe; endproperty
	property p_busy_len; nv_busy |-> busy_cnt <= PROGRAM_CYCLES; endproperty
	property p_busy_cause; $rose(nv_busy) |-> $past(nv_commit); endproperty
	property p_recall; $rose(powered_up) |-> recall_zero; endproperty
	property p_recall_pulse; recall_zero |=> !recall_zero && powered_up; endproperty
	property p_hold; s_stall |=> s_held; endproperty
	property p_taken; tx_taken |=> !tx_taken; endproperty
	a_od: assert property (p_od) else $error("data pin driven high");
	a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
	a_pwr_quiet: assert property (p_pwr_quiet) else $error("ack before power-up");
	a_busy_len: assert property (p_busy_len) else $error("programming too long");
	a_busy_cause: assert property (p_busy_cause) else $error("busy without commit");
	a_recall: assert property (p_recall) else $error("no recall at power-up");
	a_recall_pulse: assert property (p_recall_pulse) else $error("recall not a pulse");
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	a_taken: assert property (p_taken) else $error("tx_taken not a pulse");
endmodule
bind pot_i2c_slave pot_i2c_chk #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) chk (
	.clock(clock), .rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe),
	.rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_taken(tx_taken), .nv_commit(nv_commit), .nv_busy(nv_busy),
	.powered_up(powered_up), .recall_zero(recall_zero));

/* File: test/pot_bus_master.sv */
// behavioural two-wire bus master with pulled-up lines
// assumes the device pulls data low through its enable
`timescale 1ns/1ns
module pot_bus_master (
	// device side of the data pin
	input  wire logic dev_oe,
	input  wire logic dev_out,
	// resolved lines
	output logic      scl,
	output logic      sda
);
	logic drive_low;
	// wired-and with pull-up: a released line reads high
	assign sda = (drive_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
	initial begin
		scl = 1'b1;
		drive_low = 1'b0;
	end
	// clock stands high between frames
	task automatic start();
		drive_low = 1'b0;
		#100 drive_low = 1'b1;
		#100 scl = 1'b0;
	endtask
	task automatic stop();
		#60 drive_low = 1'b1;
		#170 scl = 1'b1;
		#80 drive_low = 1'b0;
		#330;
	endtask
	// long low phase leaves room for the device's filter latency
	task automatic bit_io(input logic b, output logic got);
		#60 drive_low = !b;
		#170 scl = 1'b1;
		#80 got = sda;
		#10 scl = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(d[i], g);
		bit_io(1'b1, g);
		ack = !g;
	endtask
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!ack, g);
	endtask
endmodule

/* File: test/pot_i2c_slave_front_end_tb.sv */
// self-checking bench for the serial slave front end
// assumes the bus master model and short power-up and programming counts
`timescale 1ns/1ns
`include "pot_i2c_params.svh"
module pot_i2c_slave_front_end_tb;
	localparam int PWR = 50;
	localparam int PRG = 200;
	localparam logic [7:0] ADR = {`POT_TYPE_ID, 4'h3};
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       scl, sda, sda_out, sda_oe, rx_first, rx_valid, tx_taken, nv_busy;
	logic       powered_up, recall_zero;
	logic       rx_ready = 1'b1;
	logic       read_next = 1'b0;
	logic       nv_commit = 1'b0;
	logic [3:0] strap = 4'h3;
	logic [7:0] rx_data, d;
	logic [7:0] tx_data = 8'h96;
	logic [8:0] got[$];
	logic       ack;
	int         error_cnt = 0;
	int         compares = 0;
	int         taken_cnt = 0;
	always #20 clock = ~clock;
	pot_i2c_slave #(.POWERUP_CYCLES(PWR), .PROGRAM_CYCLES(PRG)) uut (
		.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
		.strap_addr_bit2(strap[2]), .strap_addr_bit3(strap[3]), .rx_data(rx_data),
		.rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.read_next(read_next), .tx_data(tx_data), .tx_taken(tx_taken),
		.nv_commit(nv_commit), .nv_busy(nv_busy), .powered_up(powered_up),
		.recall_zero(recall_zero));
	pot_bus_master m (.dev_oe(sda_oe), .dev_out(sda_out), .scl(scl), .sda(sda));
	// record bytes the datapath takes; swap read byte once the device loaded it
	always @(posedge clock) if (rx_valid && rx_ready) got.push_back({rx_first, rx_data});
	always @(negedge clock) if (tx_taken) begin
		tx_data <= 8'h3D;
		taken_cnt <= taken_cnt + 1;
	end
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic t_powerup();
		int n = 0;
		check("powered_up early", 9'h0, 9'(powered_up));
		while (!powered_up && n < PWR + 10) begin
			@(negedge clock);
			n++;
		end
		check("powerup delay ok", 9'h1, 9'(n >= PWR - 3 && n <= PWR + 3));
		// the recall pulse rises on the same edge as powered_up and lasts one cycle
		check("recall pulse", 9'h1, 9'(recall_zero));
		$display("test powerup done");
	endtask
	// one address-only frame per flipped bit: type field and each strap bit
	task automatic t_address();
		logic [7:0] bad[5] = '{ADR ^ 8'h80, ADR ^ 8'h01, ADR ^ 8'h02, ADR ^ 8'h04, ADR ^ 8'h08};
		foreach (bad[i]) begin
			m.start();
			m.put_byte(bad[i], ack);
			check("mismatch ack", 9'h0, 9'(ack));
			m.stop();
		end
		// a matching address clocked in without a START must be ignored
		m.put_byte(ADR, ack);
		check("no start ack", 9'h0, 9'(ack));
		m.stop();
		$display("test address done");
	endtask
	task automatic t_write();
		int n = 0;
		got.delete();
		@(negedge clock) nv_commit = 1'b1;
		m.start();
		m.put_byte(ADR, ack);
		check("addr ack", 9'h1, 9'(ack));
		m.put_byte(8'hC6, ack);
		check("instr ack", 9'h1, 9'(ack));
		m.put_byte(8'h2B, ack);
		check("data ack", 9'h1, 9'(ack));
		m.stop();
		check("bytes", 9'h2, 9'(got.size()));
		if (got.size() == 2) begin
			check("instr byte", 9'h1C6, got[0]);
			check("data byte", 9'h02B, got[1]);
		end
		check("busy", 9'h1, 9'(nv_busy));
		@(negedge clock) nv_commit = 1'b0;
		m.start();
		m.put_byte(ADR, ack);
		check("poll busy", 9'h0, 9'(ack));
		m.stop();
		while (nv_busy && n < PRG + 20) begin
			@(negedge clock);
			n++;
		end
		check("busy ends", 9'h0, 9'(nv_busy));
		m.start();
		m.put_byte(ADR, ack);
		check("poll done", 9'h1, 9'(ack));
		m.stop();
		$display("test write done");
	endtask
	task automatic t_read();
		got.delete();
		@(negedge clock) read_next = 1'b1;
		m.start();
		m.put_byte(ADR, ack);
		check("read addr ack", 9'h1, 9'(ack));
		m.put_byte(8'h9C, ack);
		check("read instr ack", 9'h1, 9'(ack));
		m.get_byte(1'b1, d);
		check("read 1", 9'h096, 9'(d));
		m.get_byte(1'b1, d);
		check("read 2", 9'h03D, 9'(d));
		m.get_byte(1'b0, d);
		m.get_byte(1'b0, d);
		check("after nack", 9'h0FF, 9'(d));
		m.stop();
		check("loads", 9'h3, 9'(taken_cnt));
		@(negedge clock) read_next = 1'b0;
		$display("test read done");
	endtask
	// receiver stalls: two bytes fit, the third is refused, nothing is lost
	task automatic t_full();
		got.delete();
		@(negedge clock) rx_ready = 1'b0;
		m.start();
		m.put_byte(ADR, ack);
		m.put_byte(8'h11, ack);
		m.put_byte(8'h22, ack);
		check("second ack", 9'h1, 9'(ack));
		m.put_byte(8'h33, ack);
		check("full nack", 9'h0, 9'(ack));
		m.stop();
		@(negedge clock) rx_ready = 1'b1;
		repeat (10) @(negedge clock);
		check("drained", 9'h2, 9'(got.size()));
		if (got.size() == 2) check("order", 9'h022, got[1]);
		$display("test full done");
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		t_powerup();
		t_address();
		t_write();
		t_read();
		t_full();
		final_report();
	end
endmodule
